// ==== logic/ckc_pkg.sv ====
package ckc_pkg;
	localparam logic [7:0] OFS_DRIVE_GFX = 8'h09;
	localparam logic [7:0] OFS_MN_REFDRV = 8'h0A;
	localparam logic [7:0] OFS_VCO_HIGH  = 8'h0B;
	localparam logic [7:0] OFS_VCO_LOW   = 8'h0C;
	localparam logic [7:0] OFS_SPR_LOW   = 8'h0D;
	localparam logic [7:0] OFS_SPR_HIGH  = 8'h0E;
	// Writable bit masks; reserved bits read zero
	localparam logic [7:0] MSK_DRIVE_GFX = 8'hEF;
	localparam logic [7:0] MSK_MN_REFDRV = 8'hE0;
	localparam logic [7:0] MSK_FULL      = 8'hFF;
	localparam logic [7:0] MSK_SPR_HIGH  = 8'h7F;
	// Reset values
	localparam logic [7:0] RST_DRIVE_GFX = 8'hE0;
	localparam logic [7:0] RST_MN_REFDRV = 8'h60;
	// Divider and spread power-up values, arbitrary neutral defaults
	localparam logic [7:0] RST_VCO_HIGH  = 8'h00;
	localparam logic [7:0] RST_VCO_LOW   = 8'h00;
	localparam logic [7:0] RST_SPR_LOW   = 8'h00;
	localparam logic [7:0] RST_SPR_HIGH  = 8'h00;
	// Field positions
	localparam int POS_REF2_DRV  = 7;
	localparam int POS_USB1_DRV  = 6;
	localparam int POS_USB0_DRV  = 5;
	localparam int POS_GFX_MSB   = 3;
	localparam int POS_MN_EN     = 7;
	localparam int POS_REF1_DRV  = 6;
	localparam int POS_REF0_DRV  = 5;
	localparam int POS_N_BIT8    = 7;
	localparam int POS_N_BIT9    = 6;
	localparam int POS_M_MSB     = 5;
	localparam int POS_SPRH_MSB  = 6;
	// Divider offsets of the VCO equation
	localparam logic [10:0] N_OFFSET = 11'h008;
	localparam logic [6:0]  M_OFFSET = 7'h02;
endpackage

// ==== logic/ckc_reg8.sv ====
`timescale 1ns/1ps
module ckc_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MSK  = 8'hFF
) (
	input  wire logic       I_CLK_SYS,
	input  wire logic       I_NRST,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_q
);
	logic [7:0] reg_q;
	logic [7:0] reg_d;

	assign reg_d = i_we ? (i_wdata & WR_MSK) : reg_q;
	assign o_q = reg_q;

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			reg_q <= RST_VAL & WR_MSK;
		end else begin
			reg_q <= reg_d;
		end
	end
endmodule

// ==== logic/ckc_regs.sv ====
`timescale 1ns/1ps
module ckc_regs (
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_NRST,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	output logic             o_rvalid,
	output logic             o_ref2_drive_sel,
	output logic             o_usb_clk1_drive_sel,
	output logic             o_usb_clk0_drive_sel,
	output logic             o_ref_out1_drive_sel,
	output logic             o_ref_out0_drive_sel,
	output logic      [3:0]  o_gfx_freq_sel,
	output logic             o_mn_prog_en,
	output logic      [9:0]  o_cpu_vco_feedback,
	output logic      [5:0]  o_cpu_vco_ref_div,
	output logic      [10:0] o_vco_mult,
	output logic      [6:0]  o_vco_div,
	output logic      [14:0] o_cpu_spread
);
	////////////////////////////////////////////////////////////////
	logic [7:0] b9;
	logic [7:0] b10;
	logic [7:0] b11;
	logic [7:0] b12;
	logic [7:0] b13;
	logic [7:0] b14;
	logic       we9;
	logic       we10;
	logic       we11;
	logic       we12;
	logic       we13;
	logic       we14;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign we9  = i_wr && hit(i_addr, ckc_pkg::OFS_DRIVE_GFX);
	assign we10 = i_wr && hit(i_addr, ckc_pkg::OFS_MN_REFDRV);
	assign we11 = i_wr && hit(i_addr, ckc_pkg::OFS_VCO_HIGH);
	assign we12 = i_wr && hit(i_addr, ckc_pkg::OFS_VCO_LOW);
	assign we13 = i_wr && hit(i_addr, ckc_pkg::OFS_SPR_LOW);
	assign we14 = i_wr && hit(i_addr, ckc_pkg::OFS_SPR_HIGH);

	// Masks force reserved bits to zero at write and reset
	ckc_reg8 #(.RST_VAL(ckc_pkg::RST_DRIVE_GFX), .WR_MSK(ckc_pkg::MSK_DRIVE_GFX)) u_b9 (
		.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .i_we(we9), .i_wdata(i_wdata), .o_q(b9));
	ckc_reg8 #(.RST_VAL(ckc_pkg::RST_MN_REFDRV), .WR_MSK(ckc_pkg::MSK_MN_REFDRV)) u_b10 (
		.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .i_we(we10), .i_wdata(i_wdata), .o_q(b10));
	ckc_reg8 #(.RST_VAL(ckc_pkg::RST_VCO_HIGH), .WR_MSK(ckc_pkg::MSK_FULL)) u_b11 (
		.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .i_we(we11), .i_wdata(i_wdata), .o_q(b11));
	ckc_reg8 #(.RST_VAL(ckc_pkg::RST_VCO_LOW), .WR_MSK(ckc_pkg::MSK_FULL)) u_b12 (
		.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .i_we(we12), .i_wdata(i_wdata), .o_q(b12));
	ckc_reg8 #(.RST_VAL(ckc_pkg::RST_SPR_LOW), .WR_MSK(ckc_pkg::MSK_FULL)) u_b13 (
		.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .i_we(we13), .i_wdata(i_wdata), .o_q(b13));
	ckc_reg8 #(.RST_VAL(ckc_pkg::RST_SPR_HIGH), .WR_MSK(ckc_pkg::MSK_SPR_HIGH)) u_b14 (
		.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .i_we(we14), .i_wdata(i_wdata), .o_q(b14));

	////////////////////////////////////////////////////////////////
	logic [9:0]  n_val;
	logic [5:0]  m_val;
	logic [10:0] mult_d;
	logic [6:0]  div_d;
	logic [7:0]  rsel;
	logic [7:0]  rdata_d;

	assign n_val = {b11[ckc_pkg::POS_N_BIT9], b11[ckc_pkg::POS_N_BIT8], b12};
	assign m_val = b11[ckc_pkg::POS_M_MSB:0];
	// Terms of the VCO ratio; zero ratio while programming is off
	assign mult_d = b10[ckc_pkg::POS_MN_EN] ? ({1'b0, n_val} + ckc_pkg::N_OFFSET) : 11'h000;
	assign div_d  = b10[ckc_pkg::POS_MN_EN] ? ({1'b0, m_val} + ckc_pkg::M_OFFSET) : 7'h00;

	always_comb begin
		rsel = 8'h00;
		case (i_addr)
			ckc_pkg::OFS_DRIVE_GFX: rsel = b9;
			ckc_pkg::OFS_MN_REFDRV: rsel = b10;
			ckc_pkg::OFS_VCO_HIGH:  rsel = b11;
			ckc_pkg::OFS_VCO_LOW:   rsel = b12;
			ckc_pkg::OFS_SPR_LOW:   rsel = b13;
			ckc_pkg::OFS_SPR_HIGH:  rsel = b14;
			default:                rsel = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Read answer stands until the next read strobe
	assign rdata_d = i_rd ? rsel : o_rdata;

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rdata  <= rdata_d;
			o_rvalid <= i_rd;
		end
	end

	// Field outputs registered so consumers see clean flop levels
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			o_ref2_drive_sel     <= 1'b1;
			o_usb_clk1_drive_sel <= 1'b1;
			o_usb_clk0_drive_sel <= 1'b1;
			o_ref_out1_drive_sel <= 1'b1;
			o_ref_out0_drive_sel <= 1'b1;
			o_gfx_freq_sel       <= 4'h0;
			o_mn_prog_en         <= 1'b0;
			o_cpu_vco_feedback   <= 10'h000;
			o_cpu_vco_ref_div    <= 6'h00;
			o_vco_mult           <= 11'h000;
			o_vco_div            <= 7'h00;
			o_cpu_spread         <= 15'h0000;
		end else begin
			o_ref2_drive_sel     <= b9[ckc_pkg::POS_REF2_DRV];
			o_usb_clk1_drive_sel <= b9[ckc_pkg::POS_USB1_DRV];
			o_usb_clk0_drive_sel <= b9[ckc_pkg::POS_USB0_DRV];
			o_ref_out1_drive_sel <= b10[ckc_pkg::POS_REF1_DRV];
			o_ref_out0_drive_sel <= b10[ckc_pkg::POS_REF0_DRV];
			o_gfx_freq_sel       <= b9[ckc_pkg::POS_GFX_MSB:0];
			o_mn_prog_en         <= b10[ckc_pkg::POS_MN_EN];
			o_cpu_vco_feedback   <= n_val;
			o_cpu_vco_ref_div    <= m_val;
			o_vco_mult           <= mult_d;
			o_vco_div            <= div_d;
			o_cpu_spread         <= {b14[ckc_pkg::POS_SPRH_MSB:0], b13};
		end
	end

	////////////////////////////////////////////////////////////////
	// Field outputs trail a write strobe by two edges
	a_drive_after_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we9 |-> ##2 (o_ref2_drive_sel == $past(i_wdata[7], 2)))
		else $error("drive select did not follow write");
	a_usb1_drive_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we9 |-> ##2 (o_usb_clk1_drive_sel == $past(i_wdata[6], 2)))
		else $error("usb clock 1 drive select did not follow write");
	a_usb0_drive_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we9 |-> ##2 (o_usb_clk0_drive_sel == $past(i_wdata[5], 2)))
		else $error("usb clock 0 drive select did not follow write");
	a_ref_drive_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we10 |-> ##2 (o_ref_out0_drive_sel == $past(i_wdata[5], 2)))
		else $error("ref drive select did not follow write");
	a_ref1_drive_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we10 |-> ##2 (o_ref_out1_drive_sel == $past(i_wdata[6], 2)))
		else $error("ref 1 drive select did not follow write");
	a_gfx_sel_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we9 |-> ##2 (o_gfx_freq_sel == $past(i_wdata[3:0], 2)))
		else $error("graphics select mismatch");
	a_mn_en_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we10 |-> ##2 (o_mn_prog_en == $past(i_wdata[7], 2)))
		else $error("divider enable did not follow write");
	a_n_high_bits: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we11 |-> ##2 (o_cpu_vco_feedback[9:8] == {$past(i_wdata[6], 2), $past(i_wdata[7], 2)}))
		else $error("N high bits misplaced");
	a_m_low_field: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we11 |-> ##2 (o_cpu_vco_ref_div == $past(i_wdata[5:0], 2)))
		else $error("M field misplaced");
	a_n_low_bits: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we12 |-> ##2 (o_cpu_vco_feedback[7:0] == $past(i_wdata, 2)))
		else $error("N low bits mismatch");
	a_spread_low: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we13 |-> ##2 (o_cpu_spread[7:0] == $past(i_wdata, 2)))
		else $error("spread low bits mismatch");
	a_spread_high: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		we14 |-> ##2 (o_cpu_spread[14:8] == $past(i_wdata[6:0], 2)))
		else $error("spread high bits mismatch");

	// Ratio terms and their gating
	a_ratio_terms: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		o_mn_prog_en |-> (o_vco_mult == {1'b0, o_cpu_vco_feedback} + ckc_pkg::N_OFFSET))
		else $error("multiplier term wrong");
	a_m_field: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		o_mn_prog_en |-> (o_vco_div == {1'b0, o_cpu_vco_ref_div} + ckc_pkg::M_OFFSET))
		else $error("divider term wrong");
	a_mn_disabled: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		!o_mn_prog_en |-> (o_vco_mult == 11'h000 && o_vco_div == 7'h00))
		else $error("ratio applied while disabled");

	// Reset defaults, seen at the first edge after release
	a_reset_drive_dflt: assert property (@(posedge I_CLK_SYS) $rose(I_NRST) |->
		(o_ref2_drive_sel && o_usb_clk1_drive_sel && o_usb_clk0_drive_sel
		&& o_ref_out1_drive_sel && o_ref_out0_drive_sel))
		else $error("drive selects not double after reset");
	a_reset_field_dflt: assert property (@(posedge I_CLK_SYS) $rose(I_NRST) |->
		(o_gfx_freq_sel == 4'h0 && !o_mn_prog_en))
		else $error("select or enable not zero after reset");

	// Read path: answer one edge after the strobe
	a_mn_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(i_rd && i_addr == ckc_pkg::OFS_MN_REFDRV) |=> (o_rdata[4:0] == 5'h00))
		else $error("reserved bits read nonzero");
	a_gfx_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(i_rd && i_addr == ckc_pkg::OFS_DRIVE_GFX) |=> (o_rdata[4] == 1'b0))
		else $error("drive register reserved bit read nonzero");
	a_spr_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(i_rd && i_addr == ckc_pkg::OFS_SPR_HIGH) |=> (o_rdata[7] == 1'b0))
		else $error("spread reserved bit read nonzero");
	a_read_drive_gfx: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(i_rd && i_addr == ckc_pkg::OFS_DRIVE_GFX) |=> (o_rdata == {o_ref2_drive_sel,
		o_usb_clk1_drive_sel, o_usb_clk0_drive_sel, 1'b0, o_gfx_freq_sel}))
		else $error("drive register read differs from field outputs");
	a_read_mn_refdrv: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(i_rd && i_addr == ckc_pkg::OFS_MN_REFDRV) |=> (o_rdata[7:5] == {o_mn_prog_en,
		o_ref_out1_drive_sel, o_ref_out0_drive_sel}))
		else $error("enable register read differs from field outputs");
	a_read_spread_low: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(i_rd && i_addr == ckc_pkg::OFS_SPR_LOW) |=> (o_rdata == o_cpu_spread[7:0]))
		else $error("spread low read differs from field output");
	a_rvalid_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		i_rd |=> o_rvalid)
		else $error("read valid missing after strobe");
	a_rvalid_single: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		o_rvalid |-> $past(i_rd))
		else $error("read valid without strobe");
	a_rdata_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
		!i_rd |=> $stable(o_rdata))
		else $error("read data changed without a read");
endmodule

// ==== test/ckc_host.sv ====
`timescale 1ns/1ps
module ckc_host (
	input  wire logic       i_clk,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata
);
	initial begin
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end
	// One-cycle strobe; returns at the negedge where a read answer stands
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr    = w;
		o_rd    = ~w;
		o_addr  = a;
		o_wdata = d;
		@(negedge i_clk);
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		// Idle bus shows no stale value
		o_addr  = ~a;
		o_wdata = ~d;
	endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic        clk_sys;
	logic        nrst;
	logic        wr;
	logic        rd;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        rvalid;
	logic [4:0]  drv;
	logic [3:0]  gfx;
	logic        mn_en;
	logic [9:0]  fb;
	logic [5:0]  rdiv;
	logic [10:0] mult;
	logic [6:0]  vdiv;
	logic [14:0] spread;
	int          num_errors;
	int          samples_checked;
	logic [7:0]  ofs [6] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
	logic [7:0]  rst [6] = '{8'hE0, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk [6] = '{8'hEF, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'h7F};

	always #2.5 clk_sys = ~clk_sys;

	ckc_host i_ckc_host (.i_clk(clk_sys), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	ckc_regs i_ckc_regs (.I_CLK_SYS(clk_sys), .I_NRST(nrst), .i_wr(wr), .i_rd(rd),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_ref2_drive_sel(drv[4]), .o_usb_clk1_drive_sel(drv[3]),
		.o_usb_clk0_drive_sel(drv[2]), .o_ref_out1_drive_sel(drv[1]),
		.o_ref_out0_drive_sel(drv[0]), .o_gfx_freq_sel(gfx), .o_mn_prog_en(mn_en),
		.o_cpu_vco_feedback(fb), .o_cpu_vco_ref_div(rdiv), .o_vco_mult(mult),
		.o_vco_div(vdiv), .o_cpu_spread(spread));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		i_ckc_host.xfer(1'b1, a, d);
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		i_ckc_host.xfer(1'b0, a, 8'h00);
		chk("read", {8'h01, e}, {7'h00, rvalid, rdata});
		@(negedge clk_sys);
		chk("read hold", {8'h00, e}, {7'h00, rvalid, rdata});
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		num_errors++;
		stop_test();
	end

	initial begin
		clk_sys = 1'b0;
		nrst    = 1'b0;
		repeat (12) @(negedge clk_sys);
		nrst = 1'b1;
		chk("reset outs", 16'h1F00, {3'h0, drv, gfx, 3'h0, mn_en});
		for (int i = 0; i < 6; i++) rd_chk(ofs[i], rst[i]);
		for (int i = 0; i < 6; i++) wr_reg(ofs[i], 8'hFF);
		for (int i = 0; i < 6; i++) rd_chk(ofs[i], msk[i]);
		for (int i = 0; i < 6; i++) wr_reg(ofs[i], 8'h00);
		for (int i = 0; i < 6; i++) rd_chk(ofs[i], 8'h00);
		wr_reg(8'h0F, 8'hFF);
		rd_chk(8'h0F, 8'h00);
		rd_chk(8'h08, 8'h00);
		wr_reg(8'h09, 8'h6A);
		wr_reg(8'h0A, 8'h40);
		wr_reg(8'h0B, 8'h85);
		wr_reg(8'h0C, 8'h34);
		chk("drive gfx", 16'h0E0A, {3'h0, drv, 4'h0, gfx});
		chk("ratio off", 16'h0000, {5'h00, mult});
		chk("div off", 16'h0000, {9'h000, vdiv});
		chk("n m", {16'h0134}, {6'h00, fb});
		wr_reg(8'h0A, 8'hC0);
		chk("m", 16'h0105, {7'h00, mn_en, 2'h0, rdiv});
		chk("mult", 16'h013C, {5'h00, mult});
		chk("div", 16'h0007, {9'h000, vdiv});
		wr_reg(8'h0B, 8'h7F);
		chk("n hi", 16'h0234, {6'h00, fb});
		chk("mult hi", 16'h023C, {5'h00, mult});
		chk("div hi", 16'h0041, {9'h000, vdiv});
		wr_reg(8'h0D, 8'h5A);
		wr_reg(8'h0E, 8'hA3);
		chk("spread", 16'h235A, {1'b0, spread});
		nrst = 1'b0;
		@(negedge clk_sys);
		nrst = 1'b1;
		chk("re-reset", 16'h1F00, {3'h0, drv, 7'h00, mn_en});
		rd_chk(8'h0E, 8'h00);
		stop_test();
	end
endmodule
